// ---- rtl/bdcc_regs.svh ----
// Constants of the backup-domain calendar clock
// Assumes inclusion by bare name from the store and core modules
`ifndef BDCC_REGS_SVH
`define BDCC_REGS_SVH
// Prescaler reset values: 128 x 256 = 32768 steps per second
`define BDCC_PRE_A_RST 7'h7f
`define BDCC_PRE_S_RST 13'h00ff
// High-speed source is divided by 128
`define BDCC_HSE_DIV_MAX 7'h7f
// Calibration output toggles every 32 calendar clocks
`define BDCC_CAL_DIV_MAX 5'h1f
// Storage geometry
`define BDCC_WORD_W 32
`define BDCC_BKP_REGS 20
`define BDCC_BKP_AW 5
`define BDCC_SRAM_WORDS 1024
`define BDCC_SRAM_AW 10
// Calendar reset values
`define BDCC_SEC_RST 8'h00
`define BDCC_MIN_RST 8'h00
`define BDCC_HOUR_RST 8'h00
`define BDCC_WDAY_RST 3'h1
`define BDCC_DATE_RST 8'h01
`define BDCC_MON_RST 8'h01
`define BDCC_YEAR_RST 8'h00
`endif

// ---- rtl/bdcc_pkg.sv ----
// Types of the backup-domain calendar clock
// Assumes bdcc_regs.svh on the include path
package bdcc_pkg;
  // Calendar clock source select
  typedef enum logic [1:0] {
    BDCC_SRC_LSE = 2'h0,
    BDCC_SRC_LSI = 2'h1,
    BDCC_SRC_HSE = 2'h2,
    BDCC_SRC_OFF = 2'h3
  } bdcc_src_t;

  // Whole state of the calendar core
  typedef struct packed {
    logic [2:0][2:0] sy;
    logic [2:0] lvl;
    logic [6:0] hdiv;
    logic [6:0] pre_a;
    logic [12:0] pre_s;
    logic [6:0] pa;
    logic [12:0] ps;
    logic [4:0] cdiv;
    logic calib;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic pm;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
    logic [1:0] al_flag;
    logic [3:0] wk_div;
    logic [15:0] wk_cnt;
    logic wk_flag;
  } bdcc_state_t;
endpackage

// ---- rtl/bdcc_store.sv ----
// Word storage with enable, one-cycle registered read
// Assumes same-clock requests; out-of-range words ignored
`timescale 1ns/1ps
`include "bdcc_regs.svh"
module bdcc_store
  import bdcc_pkg::*;
#(
  parameter int DEPTH = `BDCC_BKP_REGS,
  parameter int AW = `BDCC_BKP_AW
) (
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Backup-domain reset
  input wire logic enable, // Access allowed
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] addr, // Word index
  input wire logic [31:0] wdata, // Write data
  output logic [31:0] rdata // Read data
);
  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0] rdata;
  } bdcc_store_st_t;

  bdcc_store_st_t s;
  bdcc_store_st_t next_s;

  // Write and read port; disabled store reads zero
  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    if (enable && (int'(addr) < DEPTH)) begin
      next_s.rdata = s.mem[addr];
      if (wr_en) begin
        next_s.mem[addr] = wdata;
      end
    end
  end

  // Only the backup-domain reset clears the contents
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
endmodule

// ---- rtl/bdcc_core.sv ----
// Backup-domain calendar clock: sources, prescaler, BCD calendar,
// two alarms, wakeup downcounter, backup registers and SRAM.
// Assumes control ports come from core_clk logic; clock pins do not.
`timescale 1ns/1ps
`include "bdcc_regs.svh"
module bdcc_core
  import bdcc_pkg::*;
(
  input wire logic core_clk, // 20 MHz core clock
  input wire logic reset_n, // Backup-domain reset, low
  input wire logic lse_clk_in, // 32.768 kHz pin
  input wire logic lsi_clk_in, // Internal RC clock
  input wire logic hse_clk_in, // High-speed external clock
  input wire logic [1:0] clk_sel, // Calendar source
  input wire logic presc_load, // Load prescaler pulse
  input wire logic [6:0] presc_async, // Async divide minus one
  input wire logic [12:0] presc_sync, // Sync divide minus one
  input wire logic fmt_12h, // 12-hour format
  input wire logic cal_set, // Load calendar pulse
  input wire logic [7:0] set_sec, // BCD seconds
  input wire logic [7:0] set_min, // BCD minutes
  input wire logic [7:0] set_hour, // BCD hours
  input wire logic set_pm, // Afternoon
  input wire logic [2:0] set_wday, // Weekday 1..7
  input wire logic [7:0] set_date, // BCD date
  input wire logic [7:0] set_mon, // BCD month
  input wire logic [7:0] set_year, // BCD year
  input wire logic [1:0][7:0] al_sec, // Alarm seconds
  input wire logic [1:0][7:0] al_min, // Alarm minutes
  input wire logic [1:0][7:0] al_hour, // Alarm hours
  input wire logic [1:0] al_pm, // Alarm afternoon
  input wire logic [1:0][7:0] al_date, // Alarm date
  input wire logic [1:0][3:0] al_mask, // Masks: sec,min,hour,date
  input wire logic [1:0] al_clr, // Clear alarm flag pulse
  input wire logic wk_en, // Wakeup counter enable
  input wire logic [2:0] wk_sel, // Wakeup resolution
  input wire logic [15:0] wk_reload, // Wakeup reload value
  input wire logic wk_clr, // Clear wakeup flag pulse
  input wire logic bkp_we, // Backup register write
  input wire logic [4:0] bkp_addr, // Backup register index
  input wire logic [31:0] bkp_wdata, // Backup write data
  output logic [31:0] bkp_rdata, // Backup read data
  input wire logic sram_en, // Backup SRAM enable
  input wire logic sram_we, // SRAM write
  input wire logic [9:0] sram_addr, // SRAM word index
  input wire logic [31:0] sram_wdata, // SRAM write data
  output logic [31:0] sram_rdata, // SRAM read data
  output logic [7:0] cal_sec, // BCD seconds
  output logic [7:0] cal_min, // BCD minutes
  output logic [7:0] cal_hour, // BCD hours
  output logic cal_pm, // Afternoon
  output logic [2:0] cal_wday, // Weekday
  output logic [7:0] cal_date, // BCD date
  output logic [7:0] cal_mon, // BCD month
  output logic [7:0] cal_year, // BCD year
  output logic [12:0] subsec, // Binary sub-second
  output logic calib_out, // 512 Hz calibration
  output logic [1:0] alarm_flag, // Alarm flags
  output logic wake_flag, // Wakeup flag
  output logic wake_req // Wake from Stop/Standby
);
  bdcc_state_t s;
  bdcc_state_t next_s;

  // BCD increment of two digits
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  // Leap year for BCD years 00..99
  function automatic logic bcd_leap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (y[4]) begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return r;
  endfunction

  // Last day of a month as BCD
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    r = 8'h31;
    case (m)
      8'h02: r = bcd_leap(y) ? 8'h29 : 8'h28;
      8'h04: r = 8'h30;
      8'h06: r = 8'h30;
      8'h09: r = 8'h30;
      8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  logic [2:0] rise;
  logic tick;
  logic a_tick;
  logic sec_step;
  logic day_step;
  logic wk_step;
  logic [1:0] al_hit;

  always_comb begin
    next_s = s;
    rise = 3'h0;
    tick = 1'b0;
    a_tick = 1'b0;
    sec_step = 1'b0;
    day_step = 1'b0;
    wk_step = 1'b0;
    al_hit = 2'h0;

    // Three-stage pin synchronisers; change taken when the last two stages agree
    next_s.sy[0] = {s.sy[0][1:0], lse_clk_in};
    next_s.sy[1] = {s.sy[1][1:0], lsi_clk_in};
    next_s.sy[2] = {s.sy[2][1:0], hse_clk_in};
    for (int i = 0; i < 3; i++) begin
      if (s.sy[i][1] == s.sy[i][2]) begin
        next_s.lvl[i] = s.sy[i][2];
      end
      rise[i] = !s.lvl[i] && next_s.lvl[i];
    end

    // High-speed source divided by 128
    if (rise[2]) begin
      next_s.hdiv = s.hdiv + 7'h01;
    end

    // Calendar clock source select
    case (bdcc_src_t'(clk_sel))
      BDCC_SRC_LSE: tick = rise[0];
      BDCC_SRC_LSI: tick = rise[1];
      BDCC_SRC_HSE: tick = rise[2] && (s.hdiv == `BDCC_HSE_DIV_MAX);
      default: tick = 1'b0;
    endcase

    // 512 Hz calibration output from the calendar clock
    if (tick) begin
      next_s.cdiv = s.cdiv + 5'h01;
      if (s.cdiv == `BDCC_CAL_DIV_MAX) begin
        next_s.calib = !s.calib;
      end
    end

    // Two-stage 20-bit prescaler, down counting
    if (tick) begin
      if (s.pa == 7'h00) begin
        next_s.pa = s.pre_a;
        a_tick = 1'b1;
      end else begin
        next_s.pa = s.pa - 7'h01;
      end
    end
    if (a_tick) begin
      if (s.ps == 13'h0000) begin
        next_s.ps = s.pre_s;
        sec_step = 1'b1;
      end else begin
        next_s.ps = s.ps - 13'h0001;
      end
    end
    if (presc_load) begin
      next_s.pre_a = presc_async;
      next_s.pre_s = presc_sync;
      next_s.pa = presc_async;
      next_s.ps = presc_sync;
      sec_step = 1'b0;
    end

    // Calendar advance on each second step
    if (sec_step) begin
      next_s.sec = bcd_inc(s.sec);
      if (s.sec == 8'h59) begin
        next_s.sec = 8'h00;
        next_s.min = bcd_inc(s.min);
        if (s.min == 8'h59) begin
          next_s.min = 8'h00;
          next_s.hour = bcd_inc(s.hour);
          if (fmt_12h) begin
            if (s.hour == 8'h12) begin
              next_s.hour = 8'h01;
            end else if (s.hour == 8'h11) begin
              next_s.pm = !s.pm;
              day_step = s.pm;
            end
          end else if (s.hour == 8'h23) begin
            next_s.hour = 8'h00;
            day_step = 1'b1;
          end
        end
      end
    end
    if (day_step) begin
      next_s.wday = (s.wday == 3'h7) ? 3'h1 : 3'(s.wday + 3'h1);
      next_s.date = bcd_inc(s.date);
      if (s.date == last_day(s.mon, s.year)) begin
        next_s.date = 8'h01;
        next_s.mon = bcd_inc(s.mon);
        if (s.mon == 8'h12) begin
          next_s.mon = 8'h01;
          next_s.year = (s.year == 8'h99) ? 8'h00 : bcd_inc(s.year);
        end
      end
    end

    // Software load of the calendar wins over the step
    if (cal_set) begin
      next_s.sec = set_sec;
      next_s.min = set_min;
      next_s.hour = set_hour;
      next_s.pm = fmt_12h && set_pm;
      next_s.wday = set_wday;
      next_s.date = set_date;
      next_s.mon = set_mon;
      next_s.year = set_year;
    end

    // Alarm compare on the new time, masked fields ignored
    for (int i = 0; i < 2; i++) begin
      al_hit[i] = sec_step && !cal_set;
      if (!al_mask[i][0] && (al_sec[i] != next_s.sec)) begin
        al_hit[i] = 1'b0;
      end
      if (!al_mask[i][1] && (al_min[i] != next_s.min)) begin
        al_hit[i] = 1'b0;
      end
      if (!al_mask[i][2] && (al_hour[i] != next_s.hour)) begin
        al_hit[i] = 1'b0;
      end
      if (!al_mask[i][2] && fmt_12h && (al_pm[i] != next_s.pm)) begin
        al_hit[i] = 1'b0;
      end
      if (!al_mask[i][3] && (al_date[i] != next_s.date)) begin
        al_hit[i] = 1'b0;
      end
      // Sticky flag; a hit in the clear cycle keeps it set
      if (al_clr[i]) begin
        next_s.al_flag[i] = 1'b0;
      end
      if (al_hit[i]) begin
        next_s.al_flag[i] = 1'b1;
      end
    end

    // Wakeup resolution: clock/16, /8, /4, /2, or 1 Hz step
    if (tick) begin
      next_s.wk_div = s.wk_div + 4'h1;
    end
    case (wk_sel)
      3'h0: wk_step = tick && (s.wk_div == 4'hf);
      3'h1: wk_step = tick && (s.wk_div[2:0] == 3'h7);
      3'h2: wk_step = tick && (s.wk_div[1:0] == 2'h3);
      3'h3: wk_step = tick && s.wk_div[0];
      default: wk_step = sec_step;
    endcase

    // Auto-reload wakeup downcounter
    if (wk_clr) begin
      next_s.wk_flag = 1'b0;
    end
    if (!wk_en) begin
      next_s.wk_cnt = wk_reload;
    end else if (wk_step) begin
      if (s.wk_cnt == 16'h0000) begin
        next_s.wk_cnt = wk_reload;
      end else begin
        next_s.wk_cnt = s.wk_cnt - 16'h0001;
        if (s.wk_cnt == 16'h0001) begin
          next_s.wk_flag = 1'b1;
        end
      end
    end
  end

  // State register; reset is the backup-domain reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pre_a <= `BDCC_PRE_A_RST;
      s.pre_s <= `BDCC_PRE_S_RST;
      s.pa <= `BDCC_PRE_A_RST;
      s.ps <= `BDCC_PRE_S_RST;
      s.sec <= `BDCC_SEC_RST;
      s.min <= `BDCC_MIN_RST;
      s.hour <= `BDCC_HOUR_RST;
      s.wday <= `BDCC_WDAY_RST;
      s.date <= `BDCC_DATE_RST;
      s.mon <= `BDCC_MON_RST;
      s.year <= `BDCC_YEAR_RST;
    end else begin
      s <= next_s;
    end
  end

  // Backup registers, cleared only by the backup-domain reset
  bdcc_store #(
    .DEPTH(`BDCC_BKP_REGS),
    .AW(`BDCC_BKP_AW)
  ) u_bkp (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(1'b1),
    .wr_en(bkp_we),
    .addr(bkp_addr),
    .wdata(bkp_wdata),
    .rdata(bkp_rdata)
  );

  // Backup SRAM, gated by its enable, kept in standby
  bdcc_store #(
    .DEPTH(`BDCC_SRAM_WORDS),
    .AW(`BDCC_SRAM_AW)
  ) u_sram (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(sram_en),
    .wr_en(sram_we),
    .addr(sram_addr),
    .wdata(sram_wdata),
    .rdata(sram_rdata)
  );

  // Outputs straight from the state register
  assign cal_sec = s.sec;
  assign cal_min = s.min;
  assign cal_hour = s.hour;
  assign cal_pm = s.pm;
  assign cal_wday = s.wday;
  assign cal_date = s.date;
  assign cal_mon = s.mon;
  assign cal_year = s.year;
  assign subsec = s.ps;
  assign calib_out = s.calib;
  assign alarm_flag = s.al_flag;
  assign wake_flag = s.wk_flag;
  // Any pending event requests wakeup
  assign wake_req = (|s.al_flag) || s.wk_flag;
endmodule

// ---- testbench/bdcc_core_sva.sv ----
// Checker of the calendar clock core: calendar, flags and storage outputs
// Assumes binding onto bdcc_core, one core clock domain
`timescale 1ns/1ps
module bdcc_core_sva
  import bdcc_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Reset, low
  input wire logic fmt_12h, // 12-hour format
  input wire logic cal_set, // Calendar load
  input wire logic [7:0] set_sec, // Loaded seconds
  input wire logic [2:0] set_wday, // Loaded weekday
  input wire logic [1:0] al_clr, // Alarm clears
  input wire logic wk_clr, // Wakeup clear
  input wire logic sram_en, // SRAM enable
  input wire logic [4:0] bkp_addr, // Backup index
  input wire logic [7:0] cal_sec, // Seconds
  input wire logic [7:0] cal_hour, // Hours
  input wire logic [7:0] cal_date, // Date
  input wire logic [7:0] cal_mon, // Month
  input wire logic [2:0] cal_wday, // Weekday
  input wire logic calib_out, // Calibration wave
  input wire logic [1:0] alarm_flag, // Alarm flags
  input wire logic wake_flag, // Wakeup flag
  input wire logic wake_req, // Wake request
  input wire logic [31:0] sram_rdata, // SRAM read data
  input wire logic [31:0] bkp_rdata // Backup read data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Calendar fields and their BCD ranges
  a_cal_load: assert property (cal_set |=> cal_sec == $past(set_sec) && cal_wday == $past(set_wday))
    else $error("calendar load not taken");
  a_sec_bcd: assert property (cal_sec[3:0] <= 4'h9 && cal_sec <= 8'h59)
    else $error("seconds not valid BCD");
  a_hour_24h: assert property (!fmt_12h |-> cal_hour <= 8'h23)
    else $error("hour out of 24-hour range");
  a_date_range: assert property (cal_date != 8'h00 && cal_date <= 8'h31)
    else $error("date out of range");
  a_feb_len: assert property (cal_mon == 8'h02 |-> cal_date <= 8'h29)
    else $error("february too long");
  // Calibration wave holds for at least 8 core clocks after each change
  a_calib_hold: assert property ($changed(calib_out) |=> $stable(calib_out) [*8])
    else $error("calibration output toggles too fast");
  // Flags and wake request
  a_wake_or: assert property (wake_req == ((|alarm_flag) || wake_flag))
    else $error("wake request not tied to flags");
  a_al_sticky: assert property ((alarm_flag & ~al_clr) != 2'b00 |=>
    (alarm_flag & $past(alarm_flag & ~al_clr)) == $past(alarm_flag & ~al_clr))
    else $error("alarm flag dropped without clear");
  a_wk_sticky: assert property (wake_flag && !wk_clr |=> wake_flag)
    else $error("wakeup flag dropped without clear");
  // Storage read-back of holes and disabled memory
  a_bkp_hole: assert property (bkp_addr >= 5'h14 |=> bkp_rdata == 32'h0)
    else $error("unmapped backup word not zero");
  a_sram_off: assert property (!sram_en |=> sram_rdata == 32'h0)
    else $error("disabled SRAM returned data");
  c_alarm: cover property ($rose(alarm_flag[0]));
  c_wake: cover property ($rose(wake_flag));
  c_load: cover property (cal_set);
  c_calib: cover property ($changed(calib_out));
endmodule

bind bdcc_core bdcc_core_sva bdcc_core_sva_inst (.core_clk, .reset_n, .fmt_12h, .cal_set, .set_sec, .set_wday,
  .al_clr, .wk_clr, .sram_en, .bkp_addr, .cal_sec, .cal_hour, .cal_date, .cal_mon, .cal_wday, .calib_out,
  .alarm_flag, .wake_flag, .wake_req, .sram_rdata, .bkp_rdata);

// ---- testbench/test_backup_domain_calendar_clock.sv ----
// Self-checking bench of the calendar clock core
// Assumes bdcc_core and its checker compiled before this file
`timescale 1ns/1ps
module test_backup_domain_calendar_clock;
  import bdcc_pkg::*;
  logic core_clk, reset_n, lse_clk_in, lsi_clk_in, hse_clk_in, presc_load, fmt_12h, cal_set, set_pm;
  logic wk_en, wk_clr, bkp_we, sram_en, sram_we, cal_pm, calib_out, wake_flag, wake_req, pc;
  logic [1:0] clk_sel, al_pm, al_clr, alarm_flag;
  logic [2:0] set_wday, wk_sel, cal_wday;
  logic [6:0] presc_async;
  logic [12:0] presc_sync, subsec;
  logic [7:0] set_sec, set_min, set_hour, set_date, set_mon, set_year;
  logic [7:0] cal_sec, cal_min, cal_hour, cal_date, cal_mon, cal_year;
  logic [1:0][7:0] al_sec, al_min, al_hour, al_date;
  logic [1:0][3:0] al_mask;
  logic [15:0] wk_reload;
  logic [4:0] bkp_addr;
  logic [9:0] sram_addr;
  logic [31:0] bkp_wdata, bkp_rdata, sram_wdata, sram_rdata;
  logic [31:0] dd [24];
  int n_mismatch, num_checks, m, y, nc;

  bdcc_core bdcc_core_inst (.core_clk, .reset_n, .lse_clk_in, .lsi_clk_in, .hse_clk_in, .clk_sel, .presc_load,
    .presc_async, .presc_sync, .fmt_12h, .cal_set, .set_sec, .set_min, .set_hour, .set_pm, .set_wday, .set_date,
    .set_mon, .set_year, .al_sec, .al_min, .al_hour, .al_pm, .al_date, .al_mask, .al_clr, .wk_en, .wk_sel,
    .wk_reload, .wk_clr, .bkp_we, .bkp_addr, .bkp_wdata, .bkp_rdata, .sram_en, .sram_we, .sram_addr,
    .sram_wdata, .sram_rdata, .cal_sec, .cal_min, .cal_hour, .cal_pm, .cal_wday, .cal_date, .cal_mon,
    .cal_year, .subsec, .calib_out, .alarm_flag, .wake_flag, .wake_req);

  // Core clock and slow source pins, each pin 3 cycles high and 3 low
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {lse_clk_in, lsi_clk_in, hse_clk_in} = 3'h0;
    forever begin
      repeat (3) @(negedge core_clk);
      {lse_clk_in, lsi_clk_in, hse_clk_in} = ~{lse_clk_in, lsi_clk_in, hse_clk_in};
    end
  end

  // Comparison and verdict
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // BCD helpers and month length
  function automatic logic [7:0] bcd(int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  function automatic int dim(int mo, int yr);
    if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction

  // Load the calendar with a one-cycle pulse
  task automatic set_time(input logic [23:0] hms, input logic [23:0] dmy, input logic pm);
    @(negedge core_clk);
    {set_hour, set_min, set_sec} = hms;
    {set_date, set_mon, set_year} = dmy;
    set_pm = pm;
    set_wday = 3'(1 + $urandom % 7);
    cal_set = 1;
    @(negedge core_clk);
    cal_set = 0;
  endtask
  // Wait for the next second step, bounded
  task automatic step();
    logic [7:0] s;
    int k;
    s = cal_sec;
    k = 0;
    while (cal_sec === s && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    check(k < 2000, 1);
  endtask

  initial begin
    #4_000_000;
    n_mismatch++;
    summarize();
  end

  initial begin
    void'($urandom(27943));
    {reset_n, presc_load, fmt_12h, cal_set, set_pm, wk_en, wk_clr, bkp_we, sram_en, sram_we} = '0;
    {clk_sel, al_pm, al_clr, set_wday, wk_sel, wk_reload, bkp_addr, sram_addr} = '0;
    {presc_async, presc_sync, set_sec, set_min, set_hour, set_date, set_mon, set_year} = '0;
    {al_sec, al_min, al_hour, al_date, al_mask, bkp_wdata, sram_wdata} = '0;
    repeat (20) @(negedge core_clk);
    reset_n = 1;
    @(negedge core_clk);
    check({cal_hour, cal_min, cal_sec, cal_date, cal_mon, cal_year, cal_pm}, {48'h000000010100, 1'b0});
    check({cal_wday, subsec, alarm_flag, wake_flag}, {3'h1, 13'h00ff, 3'h0});
    // One tick per second step
    presc_load = 1;
    @(negedge core_clk);
    presc_load = 0;
    // Month ends over random years, corners first
    for (int i = 0; i < 14; i++) begin
      m = (i == 0) ? 12 : (i < 3) ? 2 : 1 + $urandom % 12;
      y = (i == 0) ? 99 : (i == 1) ? 4 : (i == 2) ? 1 : $urandom % 100;
      set_time(24'h235959, {bcd(dim(m, y)), bcd(m), bcd(y)}, 0);
      step();
      // Snapshot taken right after a step, far from the next one, so no field tears
      check({cal_date, cal_mon, cal_year, cal_hour, cal_sec},
        {8'h01, bcd(m % 12 + 1), bcd(m == 12 ? (y + 1) % 100 : y), 16'h0});
    end
    // Twelve-hour rollovers
    fmt_12h = 1;
    for (int k = 0; k < 3; k++) begin
      set_time(k == 1 ? 24'h125959 : 24'h115959, 24'h100100, k == 2);
      step();
      check({cal_hour, cal_pm, cal_date}, k == 0 ? {8'h12, 1'b1, 8'h10} :
        k == 1 ? {8'h01, 1'b0, 8'h10} : {8'h12, 1'b0, 8'h11});
    end
    fmt_12h = 0;
    // Alarms on seconds; minutes ignored, then compared
    al_sec = {8'h03, 8'h03};
    al_min = {8'h01, 8'h01};
    for (int p = 0; p < 2; p++) begin
      al_mask = p ? 8'hcc : 8'hee;
      set_time(24'h0, 24'h010100, 0);
      repeat (3) step();
      @(negedge core_clk);
      check(alarm_flag, p ? 2'b00 : 2'b11);
      step();
      check(alarm_flag, p ? 2'b00 : 2'b11);
      al_clr = 2'b11;
      @(negedge core_clk);
      al_clr = 2'b00;
      check(alarm_flag, 2'b00);
    end
    // Sub-second count reloads on a step, then counts down per tick
    presc_sync = 13'h0005;
    presc_load = 1;
    @(negedge core_clk);
    presc_load = 0;
    step();
    check(subsec, 13'h0005);
    repeat (6) @(negedge core_clk);
    check(subsec, 13'h0004);
    presc_sync = 13'h0000;
    presc_load = 1;
    @(negedge core_clk);
    presc_load = 0;
    // Wakeup counter, reload 2 on second steps; enabled just after a step
    wk_sel = 3'h4;
    wk_reload = 16'h0002;
    set_time(24'h0, 24'h010100, 0);
    step();
    wk_en = 1;
    for (int k = 1; k < 6; k++) begin
      step();
      @(negedge core_clk);
      check(wake_flag, k == 2 || k == 5);
      wk_clr = 1;
      @(negedge core_clk);
      wk_clr = 0;
    end
    // Clock-divided wakeup: reload 1 on tick/16 flags every 32 ticks of 6 cycles
    wk_en = 0;
    wk_sel = 3'h0;
    wk_reload = 16'h0001;
    @(negedge core_clk);
    wk_en = 1;
    for (int k = 0; k < 2; k++) begin
      nc = 0;
      while (wake_flag !== 1'b1 && nc < 400) begin
        @(negedge core_clk);
        nc++;
      end
      if (k == 0) check(nc < 400, 1);
      else check(nc, 2 * 16 * 6 - 1);
      wk_clr = 1;
      @(negedge core_clk);
      wk_clr = 0;
    end
    // Sources: each running one steps the calendar, stopped does not
    for (int s = 0; s < 4; s++) begin
      clk_sel = 2'(s);
      set_time(24'h0, 24'h010100, 0);
      nc = 0;
      pc = calib_out;
      repeat (1000) begin
        @(negedge core_clk);
        nc += int'(calib_out !== pc);
        pc = calib_out;
      end
      check(cal_sec != 8'h00 || cal_min != 8'h00, s != 3);
      if (s == 0) check(nc == 5 || nc == 6, 1);
    end
    // Backup words and SRAM: write with SRAM enable alternating, then read all back
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 24; j++) begin
        @(negedge core_clk);
        if (p == 0) dd[j] = $urandom;
        {bkp_we, sram_we, sram_en} = {p == 0, p == 0, p == 1 || j % 2 == 1};
        {bkp_addr, sram_addr, bkp_wdata, sram_wdata} = {5'(j), 10'(j), dd[j], dd[j]};
        @(negedge core_clk);
        {bkp_we, sram_we} = 2'b00;
        @(negedge core_clk);
        check(bkp_rdata, j < 20 ? dd[j] : 32'h0);
        check(sram_rdata, (p == 0 && !sram_en) || j % 2 == 0 ? 32'h0 : dd[j]);
      end
    end
    summarize();
  end
endmodule
